// ===== src/pulldown_pkg.sv
/*
  Constants for the pad pulldown control block: register offsets, reset
  values, bit placement of the pins that the block serves, forced-on masks.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package pulldown_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] WORD_ONE_OFFSET  = 12'h000;
  localparam logic [11:0] WORD_TWO_OFFSET  = 12'h004;
  localparam logic [11:0] STATUS_OFFSET    = 12'h008;
  localparam logic [31:0] WORD_RESET_VALUE = 32'h00000000;

  // ----------------------------------------------------------------------
  // pads served: word one bits 12..0, word two bits 31..26
  // ----------------------------------------------------------------------
  localparam int          PAD_COUNT      = 19;
  localparam int          WORD_ONE_LSB   = 0;
  localparam int          WORD_ONE_BITS  = 13;
  localparam int          WORD_TWO_LSB   = 26;
  localparam int          WORD_TWO_BITS  = 6;
  localparam logic [31:0] WORD_ONE_MASK  = 32'h00001FFF;
  localparam logic [31:0] WORD_TWO_MASK  = 32'hFC000000;

  // pad index: 0..12 = word one bits 0..12, 13..18 = word two bits 26..31
  // word two: 26 rx data, 27 tx sync, 28 rx clock, 29 tx clock,
  // 30 rx sync, 31 tx data; forced pads 14..16 are tx sync and both clocks
  localparam logic [18:0] FORCED_ON_MASK    = 19'h1DFFF;
  localparam logic [18:0] PAD_RESET_VALUE   = FORCED_ON_MASK;
  // availability assumed present until the synchronised pins are seen
  localparam logic [18:0] AVAIL_RESET_VALUE = 19'h7FFFF;

endpackage

// ===== src/pad_pulldown_control.sv
/*
  Pad pulldown control: two APB-visible control words steer the pulldown
  enables of nineteen pads. Assumes the pin-multiplex logic reports per pad
  whether the selected function has a pulldown, and a mode level that is
  high in native mode; both arrive from another domain and are synchronised.
*/
// The APB register port and the register offsets were left to the implementer.
// Overview of operation
// - bit value 0 enables the pad pulldown, 1 disables it
// - forced pins keep pulldown on in reset and compatibility mode
// - other pins keep pulldown off in reset and compatibility mode
// - register bits steer the pads only in native mode
// - outside reset, no pulldown drive when the selected function has none
// - word one bits 12..0 serve 13 io5 pins, all of them forced
// - word two bits 31..26 serve serial port two; clocks, tx sync forced
`timescale 1ns/10ps
`default_nettype none

module pad_pulldown_control (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        NATIVE_MODE_IN,
  input  wire logic [18:0] PULLDOWN_AVAIL_IN,
  output logic      [18:0] PAD_PULLDOWN_EN_OUT
);

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  logic [31:0] word_one_q;
  logic [31:0] word_two_q;
  logic        setup;
  logic        hit;

  function automatic logic mapped(input logic [11:0] addr);
    mapped = (addr == pulldown_pkg::WORD_ONE_OFFSET) ||
             (addr == pulldown_pkg::WORD_TWO_OFFSET) ||
             (addr == pulldown_pkg::STATUS_OFFSET);
  endfunction

  // one wait-free access: the answer comes in the first access cycle
  assign setup = PSEL_IN && !PENABLE_IN;
  assign hit   = PSEL_IN && PENABLE_IN && PREADY_OUT;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= setup;
      PSLVERR_OUT <= setup && !mapped(PADDR_IN);
    end
  end

  // reserved bits are kept at zero whatever software writes
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      word_one_q <= pulldown_pkg::WORD_RESET_VALUE;
      word_two_q <= pulldown_pkg::WORD_RESET_VALUE;
    end else if (hit && PWRITE_IN) begin
      if (PADDR_IN == pulldown_pkg::WORD_ONE_OFFSET) begin
        word_one_q <= PWDATA_IN & pulldown_pkg::WORD_ONE_MASK;
      end
      if (PADDR_IN == pulldown_pkg::WORD_TWO_OFFSET) begin
        word_two_q <= PWDATA_IN & pulldown_pkg::WORD_TWO_MASK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------------
  logic        native_meta_q;
  logic        native_q;
  logic [18:0] avail_meta_q;
  logic [18:0] avail_q;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      // mode resets to compat; availability to present, so the forced
      // pads stay pulled down without a gap when reset is released
      native_meta_q <= 1'b0;
      native_q      <= 1'b0;
      avail_meta_q  <= pulldown_pkg::AVAIL_RESET_VALUE;
      avail_q       <= pulldown_pkg::AVAIL_RESET_VALUE;
    end else begin
      native_meta_q <= NATIVE_MODE_IN;
      native_q      <= native_meta_q;
      avail_meta_q  <= PULLDOWN_AVAIL_IN;
      avail_q       <= avail_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // read data; status word shows live pad drive and synchronised mode
  // ----------------------------------------------------------------------
  logic [18:0] ctrl_bits;
  logic [18:0] pad_en_d;

  assign ctrl_bits = {word_two_q[31:26], word_one_q[12:0]};

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (setup && !PWRITE_IN) begin
      case (PADDR_IN)
        pulldown_pkg::WORD_ONE_OFFSET: PRDATA_OUT <= word_one_q;
        pulldown_pkg::WORD_TWO_OFFSET: PRDATA_OUT <= word_two_q;
        pulldown_pkg::STATUS_OFFSET:
          PRDATA_OUT <= {12'h000, native_q, PAD_PULLDOWN_EN_OUT};
        default: PRDATA_OUT <= 32'h00000000;
      endcase
    end else begin
      PRDATA_OUT <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // pad pulldown drive
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < pulldown_pkg::PAD_COUNT; g++) begin : g_pad
      always_comb begin
        if (!native_q) begin
          pad_en_d[g] = pulldown_pkg::FORCED_ON_MASK[g];
        end else begin
          pad_en_d[g] = !ctrl_bits[g];
        end
      end
    end
  endgenerate

  // during reset the forced pads stay pulled down, the rest stay off;
  // the mux selection is not trusted yet, so reset drive is not gated
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PAD_PULLDOWN_EN_OUT <= pulldown_pkg::PAD_RESET_VALUE;
    end else begin
      PAD_PULLDOWN_EN_OUT <= pad_en_d & avail_q;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic past_valid_q;
  always_ff @(posedge CLK_IN) begin
    past_valid_q <= RST_N_IN;
  end

  // the reset checks run without disable so that they see reset itself
  chk_reset_forced: assert property (
    @(posedge CLK_IN)
    !RST_N_IN |=> PAD_PULLDOWN_EN_OUT == pulldown_pkg::FORCED_ON_MASK)
    else $error("forced pads not pulled down in reset");
  chk_compat_forced: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    past_valid_q && !$past(native_q) |->
      PAD_PULLDOWN_EN_OUT == (pulldown_pkg::FORCED_ON_MASK & $past(avail_q)))
    else $error("compat mode pad drive wrong");
  chk_compat_off: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    past_valid_q && !$past(native_q) |->
      (PAD_PULLDOWN_EN_OUT & ~pulldown_pkg::FORCED_ON_MASK) == 19'h00000)
    else $error("unforced pad pulled in compat mode");
  chk_native_encoding: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    past_valid_q && $past(native_q) |->
      PAD_PULLDOWN_EN_OUT == (~$past(ctrl_bits) & $past(avail_q)))
    else $error("native pad drive not from bits");
  chk_native_steer: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    native_q && $stable(native_q) && avail_q[0] && !ctrl_bits[0] |=>
      PAD_PULLDOWN_EN_OUT[0])
    else $error("native bit zero not enabling");
  chk_no_pulldown: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    past_valid_q |-> (PAD_PULLDOWN_EN_OUT & ~$past(avail_q)) == 19'h00000)
    else $error("pulldown on pad without one");
  chk_word_one_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    hit && PWRITE_IN && PADDR_IN == pulldown_pkg::WORD_ONE_OFFSET |=>
      word_one_q == ($past(PWDATA_IN) & pulldown_pkg::WORD_ONE_MASK))
    else $error("word one write lost");
  chk_word_two_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    hit && PWRITE_IN && PADDR_IN == pulldown_pkg::WORD_TWO_OFFSET |=>
      word_two_q[31:26] == $past(PWDATA_IN[31:26]))
    else $error("word two write lost");
  chk_reserved_zero: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    ((word_one_q & ~pulldown_pkg::WORD_ONE_MASK) == 32'h00000000) &&
    ((word_two_q & ~pulldown_pkg::WORD_TWO_MASK) == 32'h00000000))
    else $error("reserved bit set");
  chk_reset_zero: assert property (
    @(posedge CLK_IN)
    !RST_N_IN |=> word_one_q == 32'h00000000 && word_two_q == 32'h00000000)
    else $error("control words not cleared by reset");
  chk_error_with_ready: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    PSLVERR_OUT |-> PREADY_OUT)
    else $error("error response without ready");
  chk_ready_timing: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    setup |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("ready not one cycle after setup");

  cov_native_write: cover property (@(posedge CLK_IN)
    hit && PWRITE_IN ##[1:10] native_q);
  cov_compat_forced: cover property (@(posedge CLK_IN)
    !native_q && PAD_PULLDOWN_EN_OUT[18:16] != 3'h0);
  cov_unmapped: cover property (@(posedge CLK_IN) PSLVERR_OUT);
  cov_status_read: cover property (@(posedge CLK_IN)
    hit && !PWRITE_IN && PADDR_IN == pulldown_pkg::STATUS_OFFSET);

endmodule

`default_nettype wire

// ===== dv/test_pad_pulldown_control.sv
/*
  Self-checking bench for the pad pulldown control block: APB master
  tasks, random control words and pad availability, mode changes and a
  second reset. Assumes the package and block of src/ compile first.
*/
`timescale 1ns/10ps
`default_nettype none

module test_pad_pulldown_control;
  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h00000000;
  logic        native   = 1'b0;
  logic [18:0] avail    = 19'h7FFFF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [18:0] pads;
  logic [31:0] lfsr     = 32'h9E0A32E6;
  logic [31:0] rd;
  logic [31:0] w1;
  logic [31:0] w2;
  logic        er;
  int          err_count = 0;
  int          checked   = 0;
  int          cycles    = 0;

  pad_pulldown_control pad_pulldown_control_inst (
    .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .NATIVE_MODE_IN(native),
    .PULLDOWN_AVAIL_IN(avail), .PAD_PULLDOWN_EN_OUT(pads)
  );

  always #12.5 clk = ~clk;

  // a hung handshake ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // compat mode ignores the words; a missing pulldown is never driven
  function automatic logic [18:0] exp_pads(input logic n,
    input logic [31:0] a, input logic [31:0] b, input logic [18:0] v);
    logic [18:0] bits;
    bits = {b[31:26], a[12:0]};
    return (n ? ~bits : pulldown_pkg::FORCED_ON_MASK) & v;
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the bench timeout ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int r = 0; r < 2; r++) begin
      apb(1'b0, pulldown_pkg::WORD_ONE_OFFSET, 32'h00000000);
      check(rd, 32'h00000000);
      apb(1'b0, pulldown_pkg::WORD_TWO_OFFSET, 32'h00000000);
      check(rd, 32'h00000000);
      repeat (4) @(posedge clk);
      check(pads, pulldown_pkg::FORCED_ON_MASK);
      for (int i = 0; i < 40 && r == 0; i++) begin
        lfsr = step(step(lfsr));
        // reserved positions are always written as zero
        w1 = (i == 0) ? 32'h00001FFF : lfsr & 32'h00001FFF;
        lfsr = step(step(lfsr));
        w2 = (i == 1) ? 32'hFC000000 : lfsr & 32'hFC000000;
        lfsr = step(lfsr);
        native <= (i < 4) | lfsr[19];
        avail <= (i < 2) ? 19'h7FFFF : lfsr[18:0];
        apb(1'b1, pulldown_pkg::WORD_ONE_OFFSET, w1);
        apb(1'b1, pulldown_pkg::WORD_TWO_OFFSET, w2);
        repeat (4) @(posedge clk);
        check(pads, exp_pads(native, w1, w2, avail));
        apb(1'b0, pulldown_pkg::WORD_ONE_OFFSET, 32'h00000000);
        check(rd, w1);
        apb(1'b0, pulldown_pkg::WORD_TWO_OFFSET, 32'h00000000);
        check(rd, w2);
        apb(1'b0, pulldown_pkg::STATUS_OFFSET, 32'h00000000);
        check(rd, {12'h000, native, exp_pads(native, w1, w2, avail)});
      end
      // unmapped places answer with an error and leave the words alone
      apb(1'b1, 12'h010, 32'h00000000);
      check({31'h0, er}, 32'h00000001);
      apb(1'b0, 12'h00C, 32'h00000000);
      check({31'h0, er}, 32'h00000001);
      check(rd, 32'h00000000);
      apb(1'b0, pulldown_pkg::WORD_ONE_OFFSET, 32'h00000000);
      check(rd, (r == 0) ? w1 : 32'h00000000);
      native <= 1'b0;
      avail <= 19'h7FFFF;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      check(pads, pulldown_pkg::FORCED_ON_MASK);
      rst_n <= 1'b1;
      @(posedge clk);
    end
    finish_test();
  end
endmodule

`default_nettype wire
